// ---- pkg/sfc_defines.vh ----
// Constants for the synthesizer frequency and clock output controller.
// Assumes a 40 MHz crystal clock; included by the design file by bare name.
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// Clock rate
`define SFC_CLK_MHZ          40
`define SFC_CLK_HZ           40000000

// Register byte addresses
`define SFC_ADDR_OPMODE      7'h01
`define SFC_ADDR_FRF_HIGH    7'h07
`define SFC_ADDR_FRF_MID     7'h08
`define SFC_ADDR_FRF_LOW     7'h09
`define SFC_ADDR_PIN_MAP2    7'h26
`define SFC_ADDR_STATUS      7'h27

// Operating mode field and encodings
`define SFC_MODE_MSB         4
`define SFC_MODE_LSB         2
`define SFC_SEQ_OFF_BIT      7
`define SFC_MODE_SLEEP       3'h0
`define SFC_MODE_STANDBY     3'h1
`define SFC_MODE_SYNTH       3'h2
`define SFC_MODE_TX          3'h3
`define SFC_MODE_RX          3'h4

// Clock output select field in pin map two
`define SFC_CLKSEL_MSB       2
`define SFC_CLKSEL_LSB       0
`define SFC_CLKSEL_OFF       3'h7

// Reset values
`define SFC_OPMODE_RST       8'h04
`define SFC_PIN_MAP2_RST     8'h05
`define SFC_FRF_HIGH_RST     8'h00
`define SFC_FRF_MID_RST      8'h00
`define SFC_FRF_LOW_RST      8'h00

// Status bit positions
`define SFC_ST_LOCK_BIT      4
`define SFC_ST_OSC_BIT       3
`define SFC_ST_LOCK_TO_BIT   2
`define SFC_ST_RX_BIT        1
`define SFC_ST_TX_BIT        0

// Synthesizer resolution: step is crystal over two to this power
`define SFC_SDM_BITS         19

// Timing in microseconds as printed; bit rate in bits per second
`define SFC_TX_WAKEUP_US     120
`define SFC_LOCK_TYP_US      80
`define SFC_LOCK_MAX_US      150
`define SFC_BIT_RATE_BPS     4800

`endif

// ---- hdl/sfc_synth_ctrl.v ----
// Synthesizer frequency word, sequencer hand-offs, lock indicator and clock output.
// Assumes a byte register port in the clk domain and analog status inputs from pins.
//
// Overview of operation
// - Synth step is crystal over 2^19; carrier equals step times 24-bit word.
// - Carrier word lives in three byte registers at 0x07 through 0x09.
// - Upper byte writes are held; new frequency applies only on low byte write.
// - With sequencer on, PLL starts once oscillator is stable and mode is Synth, Tx or Rx.
// - Clock output reaches the pin only after oscillator is stable.
// - Pin five carries half the reference clock or a smaller fraction chosen by clock select.
// - Clock output enabled at reset, available in every mode but Sleep.
// - With sequencer on, receiver or transmitter starts once PLL locks.
// - Lock indicator on pins goes high when PLL enters locking range.
// - Lock indicator may drop during wide FSK while transmission continues.
// - Coarse VCO calibration at reset, fine calibration at each PLL start.
// - Transmitter gives first bit clock rising edge 120 us after start.
// - Lock expected 80 us typical, 150 us at most, from Standby.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defines.vh"

module sfc_synth_ctrl #(
  parameter TX_WAKE_CYCLES  = `SFC_TX_WAKEUP_US * `SFC_CLK_MHZ,
  parameter LOCK_MAX_CYCLES = `SFC_LOCK_MAX_US * `SFC_CLK_MHZ,
  parameter BIT_HALF_CYCLES = `SFC_CLK_HZ / (2 * `SFC_BIT_RATE_BPS)
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [6:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        osc_stable_pin,
  input  wire        pll_lock_pin,
  output reg  [23:0] carrier_word_applied,
  output reg         carrier_word_load,
  output reg         pll_enable,
  output reg         coarse_cal_start,
  output reg         fine_cal_start,
  output reg         rx_enable,
  output reg         tx_enable,
  output reg         tx_bit_clock,
  output reg         lock_indicator,
  output reg         general_io_pin_five
);

  localparam ST_SLEEP = 3'd0;
  localparam ST_OSC   = 3'd1;
  localparam ST_IDLE  = 3'd2;
  localparam ST_LOCK  = 3'd3;
  localparam ST_RUN   = 3'd4;

  // Mode asks for the synthesizer
  function needs_pll;
    input [2:0] mode;
    begin
      needs_pll = (mode == `SFC_MODE_SYNTH) || (mode == `SFC_MODE_TX) ||
                  (mode == `SFC_MODE_RX);
    end
  endfunction

  // Registers
  reg  [7:0]  opmode_reg;
  reg  [7:0]  pin_map2_reg;
  reg  [7:0]  frf_high_reg;
  reg  [7:0]  frf_mid_reg;
  reg  [7:0]  frf_low_reg;

  // Pin synchronisers
  reg         osc_meta_reg;
  reg         osc_sync_reg;
  reg         lock_meta_reg;
  reg         lock_sync_reg;

  // Sequencer
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         coarse_done_reg;
  reg  [12:0] lock_cnt_reg;
  reg         lock_timeout_reg;
  reg  [12:0] tx_cnt_reg;
  reg         tx_woken_reg;
  reg  [5:0]  clk_div_reg;

  wire [2:0]  mode    = opmode_reg[`SFC_MODE_MSB:`SFC_MODE_LSB];
  wire        seq_on  = ~opmode_reg[`SFC_SEQ_OFF_BIT];
  wire [2:0]  clk_sel = pin_map2_reg[`SFC_CLKSEL_MSB:`SFC_CLKSEL_LSB];
  wire        pll_want = needs_pll(mode);
  wire        run_tx  = (mode == `SFC_MODE_TX);
  wire        run_rx  = (mode == `SFC_MODE_RX);
  wire        rx_next;
  wire        tx_next;
  wire        pll_next;

  // Two-flop synchronisers for analog status
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_meta_reg  <= 1'b0;
      osc_sync_reg  <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end
    else
    begin
      osc_meta_reg  <= osc_stable_pin;
      osc_sync_reg  <= osc_meta_reg;
      lock_meta_reg <= pll_lock_pin;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // Register writes and reads
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      opmode_reg           <= `SFC_OPMODE_RST;
      pin_map2_reg         <= `SFC_PIN_MAP2_RST;
      frf_high_reg         <= `SFC_FRF_HIGH_RST;
      frf_mid_reg          <= `SFC_FRF_MID_RST;
      frf_low_reg          <= `SFC_FRF_LOW_RST;
      carrier_word_applied <= {`SFC_FRF_HIGH_RST, `SFC_FRF_MID_RST, `SFC_FRF_LOW_RST};
      carrier_word_load    <= 1'b0;
      reg_rdata            <= 8'h00;
    end
    else
    begin
      carrier_word_load <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `SFC_ADDR_OPMODE:   opmode_reg   <= reg_wdata;
          `SFC_ADDR_PIN_MAP2: pin_map2_reg <= reg_wdata;
          `SFC_ADDR_FRF_HIGH: frf_high_reg <= reg_wdata;
          `SFC_ADDR_FRF_MID:  frf_mid_reg  <= reg_wdata;
          `SFC_ADDR_FRF_LOW:
          begin
            frf_low_reg          <= reg_wdata;
            carrier_word_applied <= {frf_high_reg, frf_mid_reg, reg_wdata};
            carrier_word_load    <= 1'b1;
          end
          default: ;
        endcase
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `SFC_ADDR_OPMODE:   reg_rdata <= opmode_reg;
          `SFC_ADDR_PIN_MAP2: reg_rdata <= pin_map2_reg;
          `SFC_ADDR_FRF_HIGH: reg_rdata <= frf_high_reg;
          `SFC_ADDR_FRF_MID:  reg_rdata <= frf_mid_reg;
          `SFC_ADDR_FRF_LOW:  reg_rdata <= frf_low_reg;
          `SFC_ADDR_STATUS:
            reg_rdata <= {3'b000, lock_sync_reg, osc_sync_reg, lock_timeout_reg,
                          rx_enable, tx_enable};
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Sequencer state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP:
        if (mode != `SFC_MODE_SLEEP)
          state_next = ST_OSC;
      ST_OSC:
        if (mode == `SFC_MODE_SLEEP)
          state_next = ST_SLEEP;
        else if (osc_sync_reg)
          state_next = ST_IDLE;
      ST_IDLE:
        if (mode == `SFC_MODE_SLEEP)
          state_next = ST_SLEEP;
        else if (pll_want && seq_on)
          state_next = ST_LOCK;
      ST_LOCK:
        if (!pll_want || !seq_on)
          state_next = ST_IDLE;
        else if (lock_sync_reg)
          state_next = ST_RUN;
      ST_RUN:
        if (!pll_want || !seq_on)
          state_next = ST_IDLE;
      default:
        state_next = ST_SLEEP;
    endcase
  end

  // Manual control drives outputs straight from mode; the host keeps its waits
  assign pll_next = seq_on ? (state_next == ST_LOCK || state_next == ST_RUN)
                           : (pll_want && mode != `SFC_MODE_SLEEP);
  assign rx_next  = seq_on ? (state_next == ST_RUN && run_rx) : run_rx;
  assign tx_next  = seq_on ? (state_next == ST_RUN && run_tx) : run_tx;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg        <= ST_SLEEP;
      pll_enable       <= 1'b0;
      rx_enable        <= 1'b0;
      tx_enable        <= 1'b0;
      fine_cal_start   <= 1'b0;
      coarse_cal_start <= 1'b0;
      coarse_done_reg  <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      pll_enable       <= pll_next;
      rx_enable        <= rx_next;
      tx_enable        <= tx_next;
      fine_cal_start   <= pll_next && !pll_enable;
      coarse_cal_start <= osc_sync_reg && !coarse_done_reg;
      if (osc_sync_reg)
        coarse_done_reg <= 1'b1;
    end
  end

  // Lock indicator follows the PLL, including drops under wide FSK
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_indicator   <= 1'b0;
      lock_cnt_reg     <= 13'h0000;
      lock_timeout_reg <= 1'b0;
    end
    else
    begin
      lock_indicator <= pll_enable && lock_sync_reg;
      if (!pll_enable || lock_sync_reg)
        lock_cnt_reg <= 13'h0000;
      else if (lock_cnt_reg != LOCK_MAX_CYCLES[12:0])
        lock_cnt_reg <= lock_cnt_reg + 13'h0001;
      // Set wins over the clear from a new PLL start
      if (pll_enable && !lock_sync_reg && lock_cnt_reg == LOCK_MAX_CYCLES[12:0] - 13'h0001)
        lock_timeout_reg <= 1'b1;
      else if (fine_cal_start)
        lock_timeout_reg <= 1'b0;
    end
  end

  // Transmit bit clock: first rising edge after wake-up delay
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_cnt_reg   <= 13'h0000;
      tx_woken_reg <= 1'b0;
      tx_bit_clock <= 1'b0;
    end
    else if (!tx_enable)
    begin
      tx_cnt_reg   <= 13'h0000;
      tx_woken_reg <= 1'b0;
      tx_bit_clock <= 1'b0;
    end
    else if (!tx_woken_reg)
    begin
      if (tx_cnt_reg == TX_WAKE_CYCLES[12:0] - 13'h0001)
      begin
        tx_woken_reg <= 1'b1;
        tx_bit_clock <= 1'b1;
        tx_cnt_reg   <= 13'h0000;
      end
      else
        tx_cnt_reg <= tx_cnt_reg + 13'h0001;
    end
    else if (tx_cnt_reg == BIT_HALF_CYCLES[12:0] - 13'h0001)
    begin
      tx_bit_clock <= ~tx_bit_clock;
      tx_cnt_reg   <= 13'h0000;
    end
    else
      tx_cnt_reg <= tx_cnt_reg + 13'h0001;
  end

  // Reference clock divider onto pin five, gated by oscillator and Sleep
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_div_reg         <= 6'h00;
      general_io_pin_five <= 1'b0;
    end
    else
    begin
      clk_div_reg <= clk_div_reg + 6'h01;
      if (!osc_sync_reg || mode == `SFC_MODE_SLEEP || clk_sel == `SFC_CLKSEL_OFF)
        general_io_pin_five <= 1'b0;
      else if (clk_sel == 3'h0)
        general_io_pin_five <= ~general_io_pin_five;
      else
        general_io_pin_five <= clk_div_reg[clk_sel - 3'h1];
    end
  end

endmodule // sfc_synth_ctrl
`default_nettype wire

// ---- verif/sfc_assertions.sv ----
// Checker for the synthesizer controller port relations.
// Bound to sfc_synth_ctrl; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sfc_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [6:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        osc_stable_pin,
  input wire logic [23:0] carrier_word_applied,
  input wire logic        carrier_word_load,
  input wire logic        pll_enable,
  input wire logic        fine_cal_start,
  input wire logic        rx_enable,
  input wire logic        tx_enable,
  input wire logic        tx_bit_clock,
  input wire logic        lock_indicator,
  input wire logic        general_io_pin_five
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_low_wr;
    reg_wr && reg_addr == 7'h09;
  endsequence
  sequence s_osc_low;
    !osc_stable_pin [*5];
  endsequence
  AST_LOW_APPLY: assert property (s_low_wr |=> carrier_word_load)
    else $error("low byte write not applied");
  AST_LOW_DATA: assert property (s_low_wr |=> carrier_word_applied[7:0] == $past(reg_wdata))
    else $error("low byte data wrong");
  AST_NO_LOAD: assert property (!reg_wr || reg_addr != 7'h09 |=> !carrier_word_load)
    else $error("load without low byte write");
  AST_WORD_HOLD: assert property (!carrier_word_load |-> $stable(carrier_word_applied))
    else $error("word changed without load");
  AST_FINE_CAL: assert property (fine_cal_start == $rose(pll_enable))
    else $error("fine calibration not tied to pll start");
  AST_LOCK_IND: assert property (lock_indicator |-> $past(pll_enable))
    else $error("lock indicator without pll");
  AST_RADIO_ON: assert property ($rose(rx_enable) || $rose(tx_enable) |-> pll_enable)
    else $error("radio on without pll");
  AST_CLK_GATE: assert property (s_osc_low |-> !general_io_pin_five)
    else $error("clock out before oscillator stable");
  AST_BIT_CLK: assert property (!tx_enable [*2] |-> !tx_bit_clock)
    else $error("bit clock while transmitter off");
endmodule // sfc_assertions

bind sfc_synth_ctrl sfc_assertions u_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .osc_stable_pin, .carrier_word_applied, .carrier_word_load, .pll_enable, .fine_cal_start,
  .rx_enable, .tx_enable, .tx_bit_clock, .lock_indicator, .general_io_pin_five);
`default_nettype wire

// ---- verif/sfc_analog_model.sv ----
// Model of the oscillator and PLL analog status pins.
// Oscillator settles after reset; lock follows pll_enable after a delay.
`timescale 1ns/100ps
`default_nettype none
module sfc_analog_model #(
  parameter int OSC_DLY  = 40,
  parameter int LOCK_DLY = 12
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pll_enable,
  input  wire logic drop_lock,
  output wire logic osc_stable_pin,
  output wire logic pll_lock_pin
);
  int oc;
  int lc;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oc <= 0;
      lc <= 0;
    end
    else
    begin
      oc <= (oc < OSC_DLY) ? oc + 1 : oc;
      lc <= !pll_enable ? 0 : (lc < LOCK_DLY) ? lc + 1 : lc;
    end
  end
  assign osc_stable_pin = (oc >= OSC_DLY);
  // Forced unlock as under wide deviation
  assign pll_lock_pin = pll_enable && lc >= LOCK_DLY && !drop_lock;
endmodule // sfc_analog_model
`default_nettype wire

// ---- verif/sfc_synth_ctrl_bench.sv ----
// Self-checking bench for the synthesizer controller.
// Drives the byte register port; analog pins come from the model.
`timescale 1ns/100ps
`default_nettype none
module sfc_synth_ctrl_bench;
  localparam int TXW = 20;
  logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, drop_lock = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00;
  wire  [7:0]  reg_rdata;
  wire  [23:0] carrier_word_applied;
  wire         carrier_word_load, pll_enable, coarse_cal_start, fine_cal_start, rx_enable;
  wire         tx_enable, tx_bit_clock, lock_indicator, general_io_pin_five, osc_stable_pin;
  wire         pll_lock_pin;
  logic [6:0]  ra [6] = '{7'h01, 7'h26, 7'h07, 7'h08, 7'h09, 7'h3f};
  logic [7:0]  re [6] = '{8'h04, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  int          mismatches = 0, check_count = 0, ncc = 0, n, p;
  always #12.5 clk = ~clk;
  always @(posedge clk)
    ncc += coarse_cal_start;
  sfc_synth_ctrl #(.TX_WAKE_CYCLES(TXW), .LOCK_MAX_CYCLES(30), .BIT_HALF_CYCLES(5)) u_dut (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_stable_pin,
    .pll_lock_pin, .carrier_word_applied, .carrier_word_load, .pll_enable, .coarse_cal_start,
    .fine_cal_start, .rx_enable, .tx_enable, .tx_bit_clock, .lock_indicator, .general_io_pin_five);
  sfc_analog_model u_ana (.clk, .nrst, .pll_enable, .drop_lock, .osc_stable_pin, .pll_lock_pin);
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write strobe stays up so writes can run back to back
  task wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
  endtask
  task idle;
    reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    chk("rdata", reg_rdata, e);
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = pll_enable;
      1: pick = tx_enable;
      2: pick = tx_bit_clock;
      3: pick = general_io_pin_five;
      default: pick = lock_indicator;
    endcase
  endfunction
  task wait_hi(input int s);
    n = 0;
    while (pick(s) !== 1'b1)
    begin
      if (n++ > 400)
      begin
        mismatches++;
        stop_test();
      end
      @(posedge clk);
      #1;
    end
  endtask
  // Clock out period between second and third rise, 0 if none
  task period(output int q);
    int r0;
    int rc;
    logic pv;
    q = 0;
    rc = 0;
    pv = general_io_pin_five;
    for (int i = 0; i < 300 && q == 0; i++)
    begin
      @(posedge clk);
      #1;
      rc += (general_io_pin_five === 1'b1 && pv === 1'b0);
      if (rc == 3)
        q = i - r0;
      if (rc == 2 && general_io_pin_five && !pv)
        r0 = i;
      pv = general_io_pin_five;
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("pin5 early", general_io_pin_five, 1'b0);
    for (int i = 0; i < 6; i++)
      rd(ra[i], re[i]);
    wait_hi(3);
    period(p);
    chk("reset reference_clock_output", p, 32);
    for (int s = 0; s < 8; s++)
    begin
      wr(7'h26, 8'(s));
      idle();
      period(p);
      chk("reference_clock_output", p, s == 7 ? 0 : s == 0 ? 2 : 1 << s);
    end
    wr(7'h26, 8'h05);
    wr(7'h01, 8'h00);
    idle();
    period(p);
    chk("sleep reference_clock_output", p, 0);
    wr(7'h01, 8'h04);
    idle();
    period(p);
    chk("standby reference_clock_output", p, 32);
    wr(7'h07, 8'he4);
    wr(7'h08, 8'hc0);
    idle();
    chk("held", carrier_word_applied, 24'h000000);
    wr(7'h09, 8'h00);
    chk("load", carrier_word_load, 1'b1);
    chk("word", carrier_word_applied, 24'he4c000);
    wr(7'h07, 8'h12);
    chk("load off", carrier_word_load, 1'b0);
    wr(7'h09, 8'h34);
    chk("word2", carrier_word_applied, 24'h12c034);
    rd(7'h07, 8'h12);
    wr(7'h01, 8'h0c);
    idle();
    wait_hi(0);
    chk("fine cal", fine_cal_start, 1'b1);
    chk("tx early", tx_enable, 1'b0);
    wait_hi(1);
    chk("lock ind", lock_indicator, 1'b1);
    wait_hi(2);
    chk("wake", n, TXW);
    for (n = 0; n < 20 && tx_bit_clock === 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("half bit", n, 5);
    drop_lock = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("tx kept", tx_enable, 1'b1);
    chk("lock drop", lock_indicator, 1'b0);
    rd(7'h27, 8'h09);
    repeat (30) @(posedge clk);
    #1;
    rd(7'h27, 8'h0d);
    drop_lock = 1'b0;
    wr(7'h01, 8'h04);
    idle();
    repeat (6) @(posedge clk);
    #1;
    wr(7'h01, 8'h88);
    idle();
    wait_hi(4);
    wr(7'h01, 8'h90);
    idle();
    rd(7'h27, 8'h1a);
    chk("coarse once", ncc, 1);
    stop_test();
  end
endmodule // sfc_synth_ctrl_bench
`default_nettype wire
